/* File: sps_far_master.sv */
// far-end master model on the serial link pins
module sps_far_master (
    output logic      sclk,
    output logic      mosi,
    output logic      ss_n,
    output logic      miso_far,
    input  wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk = 1'b0;
        mosi = 1'b0;
        ss_n = 1'b1;
        miso_far = 1'b0;
    end
    // nothing drives the far miso; a moving pattern keeps stale data from looking valid
    always #37 miso_far = ~miso_far;
    task automatic select(input logic lvl);
        #3 ss_n = lvl;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        #3 ss_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            #80 sclk = 1'b1;
            rx[i] = miso;
            #80 sclk = 1'b0;
        end
        #80 ss_n = 1'b1;
        mosi = ~mosi;  // released line must not keep showing the last bit
    endtask
endmodule

/* File: sps_if.sv */
// link between the register front end and the shifter
interface sps_if;
    logic       start;
    logic [7:0] tx_byte;
    logic       master;
    logic       run;
    logic       busy;
    logic       byte_done;
    logic [7:0] rx_byte;
    modport ctrl (output start, output tx_byte, output master, output run,
                  input busy, input byte_done, input rx_byte);
    modport shft (input start, input tx_byte, input master, input run,
                  output busy, output byte_done, output rx_byte);
endinterface

/* File: sps_pkg.sv */
// types shared by the serial status block
package sps_pkg;
    typedef enum logic [1:0] {
        SPS_IDLE,
        SPS_SHIFT,
        SPS_DONE
    } sps_state_t;
endpackage

/* File: sps_regs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH
`define SPS_OFF_DATA     12'h000
`define SPS_OFF_CSR      12'h004
`define SPS_OFF_CTRL     12'h008
`define SPS_OFF_SYS      12'h00c
`define SPS_CSR_DONE     7
`define SPS_CSR_WRITE_COLLISION_FLAG     6
`define SPS_CSR_OVR      5
`define SPS_CSR_MASTER_FAULT_FLAG     4
`define SPS_CSR_SOD      2
`define SPS_CSR_SSM      1
`define SPS_CSR_SSI      0
`define SPS_CTRL_IRQEN   0
`define SPS_CTRL_ENABLE  1
`define SPS_CTRL_MASTER  2
`define SPS_SYS_MASK     0
`define SPS_SYS_HALT     1
`define SPS_SYS_WAIT     2
`define SPS_CSR_RESET    8'h00
`define SPS_CSR_WMASK    8'h07
`define SPS_DIV_HALF     4'h8
`endif

/* File: sps_shifter.sv */
// byte shifter; master makes sclk, slave samples synchronised sclk
`include "sps_regs.svh"
module sps_shifter
    import sps_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    sps_if.shft       lk,
    input  wire logic sclk_s,
    input  wire logic sel_n,
    input  wire logic miso_s,
    input  wire logic mosi_s,
    output logic      sclk_o,
    output logic      sout
);
    sps_state_t st_q;
    logic [7:0] sh_q;
    logic [3:0] div_q;
    logic [2:0] cnt_q;
    logic       sclk_p_q;
    logic       done_q;
    logic       rise;
    logic       fall;
    logic       din;

    assign rise = lk.master ? (div_q == `SPS_DIV_HALF - 4'h1 && !sclk_o)
                            : (sclk_s && !sclk_p_q);
    assign fall = lk.master ? (div_q == `SPS_DIV_HALF - 4'h1 && sclk_o)
                            : (!sclk_s && sclk_p_q);
    assign din  = lk.master ? miso_s : mosi_s;
    assign lk.busy      = (st_q == SPS_SHIFT);
    assign lk.byte_done = done_q;
    assign lk.rx_byte   = sh_q;
    assign sout         = sh_q[7];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q     <= SPS_IDLE;
            sh_q     <= 8'h00;
            div_q    <= 4'h0;
            cnt_q    <= 3'h0;
            sclk_p_q <= 1'b0;
            sclk_o   <= 1'b0;
            done_q   <= 1'b0;
        end else if (lk.run) begin
            // run low freezes everything here: disabled, or halted unless a slave selected at halt entry
            sclk_p_q <= sclk_s;
            done_q   <= 1'b0;
            div_q    <= (div_q == `SPS_DIV_HALF - 4'h1) ? 4'h0 : div_q + 4'h1;
            case (st_q)
                SPS_IDLE: begin
                    sclk_o <= 1'b0;
                    if (lk.start) begin
                        // a slave only preloads; the far master clocks the byte out
                        sh_q  <= lk.tx_byte;
                        cnt_q <= 3'h0;
                        div_q <= 4'h0;
                        st_q  <= lk.master ? SPS_SHIFT : SPS_IDLE;
                    end else if (!lk.master && !sel_n && rise) begin
                        sh_q  <= {sh_q[6:0], din};
                        cnt_q <= 3'h1;
                        st_q  <= SPS_SHIFT;
                    end
                end
                SPS_SHIFT: begin
                    if (lk.master && div_q == `SPS_DIV_HALF - 4'h1) begin
                        sclk_o <= ~sclk_o;
                    end
                    if (!lk.master && sel_n) begin
                        st_q <= SPS_IDLE;
                    end else if (rise) begin
                        sh_q  <= {sh_q[6:0], din};
                        cnt_q <= cnt_q + 3'h1;
                        if (cnt_q == 3'h7) begin
                            st_q <= SPS_DONE;
                        end
                    end
                end
                SPS_DONE: begin
                    if (!lk.master || fall) begin
                        sclk_o <= 1'b0;
                        done_q <= 1'b1;
                        st_q   <= SPS_IDLE;
                    end
                end
                default: st_q <= SPS_IDLE;
            endcase
        end
    end
endmodule

/* File: sps_status.sv */
// serial interface status, select management and low-power behaviour
// Operation
// - keeps running and wakes chip in wait
// - halt freezes interface and its registers
// - slave transfer-done wakes chip from halt
// - second byte before clear sets overrun
// - halt wake only if select low at entry
// - one shared interrupt, enable and mask gated
// - done flag set per byte, sequence clears
// - data writes ignored until status read
// - write during transfer sets collision flag
// - overrun set on full buffer, status read clears
// - master fault on select low, cleared by sequence
// - bit 3 reserved, reads zero
// - output disable bit blocks serial output
// - select source pin or internal bit
// - internal select bit zero selects slave
// - status register resets to zero
// - master data write starts a byte
// - received byte copied to read buffer
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`include "sps_regs.svh"
module sps_status
    import sps_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sclk_i,
    input  wire logic        miso_i,
    input  wire logic        mosi_i,
    input  wire logic        ss_n_i,
    output logic             sclk_o,
    output logic             sclk_oe_n,
    output logic             mosi_o,
    output logic             mosi_oe_n,
    output logic             miso_o,
    output logic             miso_oe_n,
    output logic             irq,
    output logic             wake
);
    sps_if lk ();

    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic       done_q;
    logic       write_collision_flag_q;
    logic       ovr_q;
    logic       master_fault_flag_q;
    logic [2:0] cfg_q;
    logic [2:0] ctrl_q;
    logic [2:0] sys_q;
    logic [7:0] rbuf_q;
    logic       rd_done_q;
    logic       rd_write_collision_flag_q;
    logic       rd_master_fault_flag_q;
    logic       halt_p_q;
    logic       halt_ok_q;
    logic       start_q;
    logic [7:0] tx_q;
    logic       sclk_s;
    logic       miso_s;
    logic       mosi_s;
    logic       pin_ss_s;
    logic       sel_n;
    logic       halted;
    logic       acc;
    logic       wr_data;
    logic       rd_data;
    logic       rd_csr;
    logic       wr_csr;
    logic       wr_ctrl;
    logic       wr_sys;
    logic       mapped;
    logic       sh_out;
    logic       sh_out_clk;
    logic       drive;
    logic [7:0] csr;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction

    assign acc     = psel && penable && pready;
    assign wr_data = acc && pwrite && hit(paddr, `SPS_OFF_DATA);
    assign rd_data = acc && !pwrite && hit(paddr, `SPS_OFF_DATA);
    assign rd_csr  = acc && !pwrite && hit(paddr, `SPS_OFF_CSR);
    assign wr_csr  = acc && pwrite && hit(paddr, `SPS_OFF_CSR);
    assign wr_ctrl = acc && pwrite && hit(paddr, `SPS_OFF_CTRL);
    assign wr_sys  = acc && pwrite && hit(paddr, `SPS_OFF_SYS);
    assign mapped  = hit(paddr, `SPS_OFF_DATA) || hit(paddr, `SPS_OFF_CSR)
                  || hit(paddr, `SPS_OFF_CTRL) || hit(paddr, `SPS_OFF_SYS);

    // pins pass two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // idle pin levels: clock low, select high, so no false edge follows reset
            s1_q <= 4'h1;
            s2_q <= 4'h1;
        end else begin
            s1_q <= {sclk_i, miso_i, mosi_i, ss_n_i};
            s2_q <= s1_q;
        end
    end
    assign sclk_s   = s2_q[3];
    assign miso_s   = s2_q[2];
    assign mosi_s   = s2_q[1];
    assign pin_ss_s = s2_q[0];

    assign sel_n  = cfg_q[`SPS_CSR_SSM] ? cfg_q[`SPS_CSR_SSI] : pin_ss_s;
    assign halted = sys_q[`SPS_SYS_HALT];
    assign csr    = {done_q, write_collision_flag_q, ovr_q, master_fault_flag_q, 1'b0, cfg_q};

    assign lk.start   = start_q;
    assign lk.tx_byte = tx_q;
    assign lk.master  = ctrl_q[`SPS_CTRL_MASTER];
    // wait leaves the shifter running; halt stops it, except for a slave
    // selected at halt entry, whose received byte must be able to wake the chip
    assign lk.run     = ctrl_q[`SPS_CTRL_ENABLE]
                     && (!halted || (halt_ok_q && !ctrl_q[`SPS_CTRL_MASTER]));

    sps_shifter u_shift (
        .pclk    (pclk),
        .presetn (presetn),
        .lk      (lk),
        .sclk_s  (sclk_s),
        .sel_n   (sel_n),
        .miso_s  (miso_s),
        .mosi_s  (mosi_s),
        .sclk_o  (sh_out_clk),
        .sout    (sh_out)
    );

    // slave select capture at halt entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_p_q  <= 1'b0;
            halt_ok_q <= 1'b0;
        end else begin
            halt_p_q <= halted;
            if (halted && !halt_p_q) begin
                halt_ok_q <= !sel_n && !ctrl_q[`SPS_CTRL_MASTER];
            end
        end
    end

    // start request for the shifter; a data write when not busy and not locked by done, master or slave (a slave only preloads)
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q <= 1'b0;
            tx_q    <= 8'h00;
        end else begin
            start_q <= 1'b0;
            // a status read with done set unlocks the data register again
            if (wr_data && (!done_q || rd_done_q) && !lk.busy) begin
                tx_q    <= pwdata[7:0];
                start_q <= 1'b1;
            end
        end
    end

    // status flags; hardware set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q    <= 1'b0;
            write_collision_flag_q    <= 1'b0;
            ovr_q     <= 1'b0;
            master_fault_flag_q    <= 1'b0;
            rd_done_q <= 1'b0;
            rd_write_collision_flag_q <= 1'b0;
            rd_master_fault_flag_q <= 1'b0;
            rbuf_q    <= 8'h00;
        end else if (!halted || lk.byte_done) begin
            if (rd_csr) begin
                rd_done_q <= done_q;
                rd_write_collision_flag_q <= write_collision_flag_q;
                rd_master_fault_flag_q <= master_fault_flag_q;
            end
            if (lk.byte_done && done_q) begin
                ovr_q <= 1'b1;
            end else if (rd_csr) begin
                ovr_q <= 1'b0;
            end
            // an overrun keeps the first byte; the late one is dropped
            if (lk.byte_done && !done_q) begin
                rbuf_q <= lk.rx_byte;
            end
            if (lk.byte_done) begin
                done_q <= 1'b1;
            end else if ((rd_data || wr_data) && rd_done_q) begin
                done_q    <= 1'b0;
                rd_done_q <= 1'b0;
            end
            if (wr_data && lk.busy) begin
                write_collision_flag_q <= 1'b1;
            end else if ((rd_data || wr_data) && rd_write_collision_flag_q) begin
                write_collision_flag_q    <= 1'b0;
                rd_write_collision_flag_q <= 1'b0;
            end
            if (ctrl_q[`SPS_CTRL_MASTER] && !sel_n && ctrl_q[`SPS_CTRL_ENABLE]) begin
                master_fault_flag_q <= 1'b1;
            end else if (wr_ctrl && rd_master_fault_flag_q) begin
                master_fault_flag_q    <= 1'b0;
                rd_master_fault_flag_q <= 1'b0;
            end
        end
    end

    // configuration; csr and ctrl bits do not change while halted, sys bits stay writable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q  <= 3'(`SPS_CSR_RESET);
            ctrl_q <= 3'h0;
            sys_q  <= 3'h0;
        end else begin
            if (wr_csr && !halted) begin
                cfg_q <= pwdata[2:0] & 3'(`SPS_CSR_WMASK);
            end
            if (wr_ctrl && !halted) begin
                ctrl_q <= pwdata[2:0];
            end
            if (wr_sys) begin
                sys_q <= pwdata[2:0];
            end else if (halted && wake) begin
                sys_q[`SPS_SYS_HALT] <= 1'b0;
            end
        end
    end

    // pin outputs; a disabled output floats
    assign drive = ctrl_q[`SPS_CTRL_ENABLE] && !cfg_q[`SPS_CSR_SOD];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_o    <= 1'b0;
            sclk_oe_n <= 1'b1;
            mosi_o    <= 1'b0;
            mosi_oe_n <= 1'b1;
            miso_o    <= 1'b0;
            miso_oe_n <= 1'b1;
        end else begin
            sclk_o    <= sh_out_clk;
            sclk_oe_n <= !(ctrl_q[`SPS_CTRL_ENABLE] && ctrl_q[`SPS_CTRL_MASTER]);
            mosi_o    <= sh_out;
            mosi_oe_n <= !(drive && ctrl_q[`SPS_CTRL_MASTER]);
            miso_o    <= sh_out;
            miso_oe_n <= !(drive && !ctrl_q[`SPS_CTRL_MASTER] && !sel_n);
        end
    end

    // shared request and wake; mask bit high blocks the request
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq  <= 1'b0;
            wake <= 1'b0;
        end else begin
            irq  <= ctrl_q[`SPS_CTRL_IRQEN] && !sys_q[`SPS_SYS_MASK]
                 && (done_q || master_fault_flag_q || ovr_q);
            // only transfer done may leave halt, and only if selected at entry
            wake <= ctrl_q[`SPS_CTRL_IRQEN] && halted && halt_ok_q
                 && (done_q || lk.byte_done);
        end
    end

    // apb slave, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                if (hit(paddr, `SPS_OFF_DATA)) begin
                    prdata <= {24'h000000, rbuf_q};
                end else if (hit(paddr, `SPS_OFF_CSR)) begin
                    prdata <= {24'h000000, csr};
                end else if (hit(paddr, `SPS_OFF_CTRL)) begin
                    prdata <= {29'h00000000, ctrl_q};
                end else if (hit(paddr, `SPS_OFF_SYS)) begin
                    prdata <= {29'h00000000, sys_q};
                end
            end
        end
    end
endmodule

/* File: sps_status_checker.sv */
// port-level assertions for the serial status block
`include "sps_regs.svh"
module sps_status_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sclk_oe_n,
    input wire logic        mosi_oe_n,
    input wire logic        miso_oe_n,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] cfg_q;
    logic       ien_q, mst_q, mask_q;
    wire        acc = psel && penable;
    wire        rd_csr = acc && !pwrite && paddr == `SPS_OFF_CSR;
    wire        ok_irq = ien_q && !mask_q;
    // shadow of config bits; csr and ctrl writes while halted are mirrored though the design drops them, so the bench avoids them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q  <= 3'h0;
            ien_q  <= 1'b0;
            mst_q  <= 1'b0;
            mask_q <= 1'b0;
        end else if (acc && pwrite) begin
            if (paddr == `SPS_OFF_CSR) begin
                cfg_q <= pwdata[2:0];
            end
            if (paddr == `SPS_OFF_CTRL) begin
                ien_q <= pwdata[`SPS_CTRL_IRQEN];
                mst_q <= pwdata[`SPS_CTRL_MASTER];
            end
            if (paddr == `SPS_OFF_SYS) begin
                mask_q <= pwdata[`SPS_SYS_MASK];
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_access_ready: assert property (acc |-> pready)
        else $error("access cycle without ready");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    a_unmapped_err: assert property (acc && paddr > `SPS_OFF_SYS |-> pslverr)
        else $error("unmapped access not flagged");
    a_mapped_ok: assert property (acc && paddr[1:0] == 2'h0 && paddr <= `SPS_OFF_SYS |-> !pslverr)
        else $error("mapped access flagged");
    a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_reserved_bit: assert property (rd_csr |-> !prdata[3])
        else $error("reserved status bit set");
    a_cfg_readback: assert property (rd_csr |-> prdata[2:0] == cfg_q)
        else $error("config bits read back wrong");
    a_sod_blocks: assert property (cfg_q[2] && $past(cfg_q[2]) |-> mosi_oe_n && miso_oe_n)
        else $error("output driven while disabled");
    a_irq_gated: assert property (irq |-> ok_irq || $past(ok_irq))
        else $error("request while disabled or masked");
    a_slave_quiet: assert property (!mst_q && !$past(mst_q) |-> sclk_oe_n && mosi_oe_n)
        else $error("slave drives clock or mosi");
    c_done: cover property (rd_csr && prdata[7]);
    c_overrun: cover property (rd_csr && prdata[5]);
    c_fault: cover property (rd_csr && prdata[4]);
endmodule

/* File: sps_status_tb.sv */
// self-checking bench for the serial status block
`include "sps_regs.svh"
module sps_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] dat_a = `SPS_OFF_DATA;
    localparam logic [11:0] csr_a = `SPS_OFF_CSR;
    localparam logic [11:0] ctl_a = `SPS_OFF_CTRL;
    localparam logic [11:0] sys_a = `SPS_OFF_SYS;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, e, sclk_i, miso_i, mosi_i, ss_n_i, irq, wake;
    logic        sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
    logic [7:0]  rx;
    int          errors = 0, samples_checked = 0, cyc = 0;
    sps_status dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sclk_i, .miso_i, .mosi_i, .ss_n_i, .sclk_o, .sclk_oe_n,
        .mosi_o, .mosi_oe_n, .miso_o, .miso_oe_n, .irq, .wake);
    sps_far_master far (.sclk(sclk_i), .mosi(mosi_i), .ss_n(ss_n_i), .miso_far(miso_i),
        .miso(miso_oe_n ? 1'b1 : miso_o));
    initial begin
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd_v, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_v = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
    endtask
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // a full run is well under two thousand cycles; the ceiling leaves ample slack
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            print_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(csr_a, 32'h00);
        apb(1'b0, 12'h010, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        wr(csr_a, 32'hf7);
        rd(csr_a, 32'h07);
        wr(csr_a, 32'h04);
        wr(csr_a, 32'h00);
        wr(ctl_a, 32'h3);
        wr(sys_a, 32'h4);
        wr(dat_a, 32'h5a);
        far.xfer(8'ha5, rx);
        chk({24'h0, rx}, 32'h5a);
        rd(csr_a, 32'h80);
        chk({31'h0, irq}, 32'h1);
        rd(dat_a, 32'ha5);
        rd(csr_a, 32'h00);
        far.xfer(8'h3c, rx);
        wr(dat_a, 32'h11);
        rd(csr_a, 32'h80);
        rd(dat_a, 32'h3c);
        wr(sys_a, 32'h1);
        far.xfer(8'h01, rx);
        chk({24'h0, rx}, 32'h3c);
        far.xfer(8'h02, rx);
        chk({31'h0, irq}, 32'h0);
        rd(csr_a, 32'ha0);
        rd(csr_a, 32'h80);
        wr(sys_a, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        rd(csr_a, 32'h80);
        rd(dat_a, 32'h01);
        wr(ctl_a, 32'h7);
        wr(dat_a, 32'h96);
        wr(dat_a, 32'h11);
        r = 32'h0;
        for (int i = 0; i < 80 && r[7] !== 1'b1; i++) begin
            apb(1'b0, csr_a, 32'h0, r, e);
        end
        chk(r, 32'hc0);
        apb(1'b0, dat_a, 32'h0, r, e);
        rd(csr_a, 32'h00);
        far.select(1'b0);
        repeat (8) @(posedge pclk);
        far.select(1'b1);
        rd(csr_a, 32'h10);
        chk({31'h0, irq}, 32'h1);
        wr(ctl_a, 32'h3);
        rd(csr_a, 32'h00);
        wr(csr_a, 32'h03);
        wr(sys_a, 32'h2);
        far.xfer(8'h44, rx);
        rd(sys_a, 32'h2);
        rd(csr_a, 32'h03);
        wr(sys_a, 32'h0);
        wr(csr_a, 32'h02);
        wr(sys_a, 32'h2);
        far.xfer(8'hc3, rx);
        rd(sys_a, 32'h0);
        rd(csr_a, 32'h82);
        rd(dat_a, 32'hc3);
        far.xfer(8'h00, rx);
        rd(csr_a, 32'h82);
        print_verdict;
    end
endmodule
bind sps_status sps_status_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sclk_oe_n, .mosi_oe_n, .miso_oe_n, .irq);
